//--- rtl/remote_code_decoder.sv
// remote_code_decoder: serial 12-bit remote code word decoder.
// assumes serial_in and local_address_straps are asynchronous pins.
//
// How it works
// - first N received bits are address, remaining 12-N bits are data.
// - three consecutive words with matching address are needed to accept.
// - data outputs update only on error-free matching words, else hold.
// - on the third match data reach the outputs and the flag rises.
// - flag stays while matches continue, drops on mismatch, broken word or silence.
// - flag is high only during a valid transmission.
// - 8-address variant latches four data outputs until new valid data.
// - 12-address variant has no data; flag acts as momentary output.
// - bits 0-7 address, bits 8-11 data or address by variant.
// - oscillator stopped in standby, started by a high serial input.
`timescale 1ns/10ps
module remote_code_decoder #(
  parameter int ADDR_BITS = 8
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // link pins
  input  wire logic        serial_in,
  input  wire logic [11:0] local_address_straps,
  // outputs
  output logic       [3:0] latched_data_outputs,
  output logic             valid_transmission_flag,
  output logic             rc_osc_output
);

  localparam logic [11:0] ADDR_MASK = (ADDR_BITS == 12) ?
    remote_code_pkg::ADDR_MASK_12 : remote_code_pkg::ADDR_MASK_8;

  function automatic logic addr_ok(input remote_code_pkg::code_word_t w,
                                   input logic [11:0] straps);
    addr_ok = ((w ^ straps) & ADDR_MASK) == 12'h0000;
  endfunction : addr_ok

  remote_code_pkg::rx_state_t  state_reg;
  remote_code_pkg::rx_event_t  ev_reg;
  remote_code_pkg::code_word_t shift_reg;
  remote_code_pkg::code_word_t word_reg;
  remote_code_pkg::code_word_t shift_next;

  logic                 sin_meta_reg;
  logic                 sin_sync_reg;
  logic                 sin_prev_reg;
  logic [11:0]          strap_meta_reg;
  logic [11:0]          strap_reg;
  logic [remote_code_pkg::DIV_W-1:0] div_reg;
  logic                 tick_reg;
  logic [7:0]           cnt_reg;
  logic [3:0]           bit_idx_reg;
  logic [1:0]           match_cnt_reg;
  logic [3:0]           data_reg;
  logic                 vt_reg;
  logic                 osc_reg;
  logic                 rise;
  logic                 fall;
  logic                 word_match;
  logic                 data_load;
  logic                 drop_cause;

  // pin synchronisers; edges are taken from the second stage onward
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sin_meta_reg <= 1'b0;
      sin_sync_reg <= 1'b0;
      sin_prev_reg <= 1'b0;
    end else begin
      sin_meta_reg <= serial_in;
      sin_sync_reg <= sin_meta_reg;
      sin_prev_reg <= sin_sync_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_meta_reg <= remote_code_pkg::WORD_RESET;
      strap_reg      <= remote_code_pkg::WORD_RESET;
    end else begin
      strap_meta_reg <= local_address_straps;
      strap_reg      <= strap_meta_reg;
    end
  end

  assign rise = sin_sync_reg & ~sin_prev_reg;
  assign fall = ~sin_sync_reg & sin_prev_reg;

  // oscillator: divider runs only while awake, so standby costs no ticks
  always_ff @(posedge clk_sys) begin
    if (rst || state_reg == remote_code_pkg::ST_SLEEP) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == remote_code_pkg::DIV_W'(
                 remote_code_pkg::OSC_DIV - 1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_reg <= 1'b0;
    end else if (tick_reg) begin
      osc_reg <= ~osc_reg;
    end
  end

  assign shift_next = {sin_prev_reg && cnt_reg >=
                       remote_code_pkg::ONE_SPLIT_TICKS, shift_reg[11:1]};

  // receiver: pilot hunt, then 12 high pulses whose width carries the bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg   <= remote_code_pkg::ST_SLEEP;
      cnt_reg     <= 8'h00;
      bit_idx_reg <= 4'h0;
      shift_reg   <= remote_code_pkg::WORD_RESET;
      word_reg    <= remote_code_pkg::WORD_RESET;
      ev_reg      <= '0;
    end else begin
      ev_reg <= '0;
      if (tick_reg && cnt_reg != remote_code_pkg::TICK_CNT_MAX) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      unique case (state_reg)
        remote_code_pkg::ST_SLEEP: begin
          cnt_reg     <= 8'h00;
          bit_idx_reg <= 4'h0;
          if (sin_sync_reg) begin
            state_reg <= remote_code_pkg::ST_HUNT;
          end
        end
        remote_code_pkg::ST_HUNT: begin
          if (sin_sync_reg) begin
            cnt_reg <= 8'h00;
          end else if (cnt_reg >= remote_code_pkg::PILOT_TICKS) begin
            state_reg <= remote_code_pkg::ST_GAP;
          end
        end
        remote_code_pkg::ST_GAP: begin
          if (rise) begin
            cnt_reg   <= 8'h00;
            state_reg <= remote_code_pkg::ST_HIGH;
          end else if (bit_idx_reg == 4'h0 &&
                       cnt_reg >= remote_code_pkg::IDLE_TICKS) begin
            state_reg     <= remote_code_pkg::ST_SLEEP;
            ev_reg.ceased <= 1'b1;
          end else if (bit_idx_reg != 4'h0 &&
                       cnt_reg >= remote_code_pkg::MAX_LOW_TICKS) begin
            state_reg    <= remote_code_pkg::ST_HUNT;
            bit_idx_reg  <= 4'h0;
            ev_reg.error <= 1'b1;
          end
        end
        remote_code_pkg::ST_HIGH: begin
          if (fall) begin
            cnt_reg   <= 8'h00;
            shift_reg <= shift_next;
            if (bit_idx_reg == remote_code_pkg::LAST_BIT_IDX) begin
              bit_idx_reg <= 4'h0;
              word_reg    <= shift_next;
              ev_reg.done <= 1'b1;
              state_reg   <= remote_code_pkg::ST_HUNT;
            end else begin
              bit_idx_reg <= bit_idx_reg + 4'h1;
              state_reg   <= remote_code_pkg::ST_GAP;
            end
          end else if (cnt_reg >= remote_code_pkg::MAX_HIGH_TICKS) begin
            state_reg    <= remote_code_pkg::ST_HUNT;
            bit_idx_reg  <= 4'h0;
            ev_reg.error <= 1'b1;
          end
        end
      endcase
    end
  end

  assign word_match = addr_ok(word_reg, strap_reg);
  assign data_load  = ev_reg.done && word_match &&
                      match_cnt_reg >= remote_code_pkg::MATCHES_NEEDED - 2'h1;
  assign drop_cause = ev_reg.error || ev_reg.ceased ||
                      (ev_reg.done && !word_match);

  // triple check: count consecutive matching words, saturating at three
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      match_cnt_reg <= remote_code_pkg::MATCH_RESET;
      vt_reg        <= 1'b0;
    end else if (drop_cause) begin
      match_cnt_reg <= remote_code_pkg::MATCH_RESET;
      vt_reg        <= 1'b0;
    end else if (ev_reg.done) begin
      if (match_cnt_reg != remote_code_pkg::MATCHES_NEEDED) begin
        match_cnt_reg <= match_cnt_reg + 2'h1;
      end
      vt_reg <= data_load;
    end
  end

  // data latch; in the 12-address variant there is nothing to carry
  generate
    if (ADDR_BITS == 8) begin : g_data
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          data_reg <= remote_code_pkg::DATA_RESET;
        end else if (data_load) begin
          data_reg <= word_reg.upper;
        end
      end
    end else begin : g_no_data
      always_ff @(posedge clk_sys) begin
        data_reg <= remote_code_pkg::DATA_RESET;
      end
    end
  endgenerate

  assign latched_data_outputs    = data_reg;
  assign valid_transmission_flag = vt_reg;
  assign rc_osc_output           = osc_reg;

  a_vt_after_three: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(vt_reg) |-> $past(ev_reg.done) && $past(match_cnt_reg) == 2'h2)
    else $error("flag rose without three matching words");

  a_vt_drop_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(vt_reg) |-> $past(drop_cause))
    else $error("flag fell without mismatch, error or silence");

  a_vt_keeps_high: assert property (
    @(posedge clk_sys) disable iff (rst)
    vt_reg && ev_reg.done && word_match |=> vt_reg)
    else $error("flag dropped on a matching word");

  a_vt_only_valid: assert property (
    @(posedge clk_sys) disable iff (rst)
    vt_reg |-> match_cnt_reg == remote_code_pkg::MATCHES_NEEDED)
    else $error("flag high without full match count");

  a_data_holds: assert property (
    @(posedge clk_sys) disable iff (rst)
    !data_load |=> $stable(data_reg))
    else $error("data changed without an accepted word");

  a_data_field: assert property (
    @(posedge clk_sys) disable iff (rst)
    data_load && ADDR_BITS == 8 |=> data_reg == $past(word_reg.upper) && vt_reg)
    else $error("accepted data not on outputs with flag");

  a_mismatch_clears: assert property (
    @(posedge clk_sys) disable iff (rst)
    ev_reg.done && !word_match |=> match_cnt_reg == 2'h0 && !vt_reg)
    else $error("address mismatch did not clear the check");

  a_sleep_holds: assert property (
    @(posedge clk_sys) disable iff (rst)
    state_reg == remote_code_pkg::ST_SLEEP && !sin_sync_reg
    |=> state_reg == remote_code_pkg::ST_SLEEP ##0 !tick_reg)
    else $error("left standby without a high input");

  a_no_data_wide: assert property (
    @(posedge clk_sys) disable iff (rst)
    ADDR_BITS == 12 |-> data_reg == 4'h0)
    else $error("12-address variant drove data");

  a_reset_clear: assert property (
    @(posedge clk_sys)
    $past(rst) |-> !vt_reg && data_reg == 4'h0 && match_cnt_reg == 2'h0)
    else $error("reset did not clear flag, count and data");

  a_long_high_error: assert property (
    @(posedge clk_sys) disable iff (rst)
    state_reg == remote_code_pkg::ST_HIGH && !fall &&
    cnt_reg >= remote_code_pkg::MAX_HIGH_TICKS
    |=> ev_reg.error && state_reg == remote_code_pkg::ST_HUNT)
    else $error("overlong high pulse did not abort the word");

  a_wake_on_high: assert property (
    @(posedge clk_sys) disable iff (rst)
    state_reg == remote_code_pkg::ST_SLEEP && sin_sync_reg
    |=> state_reg == remote_code_pkg::ST_HUNT)
    else $error("high input did not wake the receiver");

  a_osc_toggles: assert property (
    @(posedge clk_sys) disable iff (rst)
    tick_reg |=> osc_reg != $past(osc_reg))
    else $error("oscillator output missed a tick");

  a_word_capture: assert property (
    @(posedge clk_sys) disable iff (rst)
    state_reg == remote_code_pkg::ST_HIGH && fall &&
    bit_idx_reg == remote_code_pkg::LAST_BIT_IDX
    |=> ev_reg.done && word_reg == $past(shift_next))
    else $error("twelfth bit did not complete the word");

  a_silence_clears: assert property (
    @(posedge clk_sys) disable iff (rst)
    ev_reg.ceased |=> !vt_reg && match_cnt_reg == 2'h0)
    else $error("silence did not clear the flag and count");

endmodule : remote_code_decoder

//--- rtl/remote_code_pkg.sv
// remote_code_pkg: constants, states and carriers of the serial code decoder.
// assumes a 125 MHz system clock; oscillator ticks come from a divider.
package remote_code_pkg;

  localparam int WORD_BITS = 12;
  localparam int CLK_KHZ   = 125_000;
  localparam int OSC_KHZ   = 150;
  // one oscillator tick every OSC_DIV system cycles (rounded down)
  localparam int OSC_DIV   = CLK_KHZ / OSC_KHZ;
  localparam int DIV_W     = 10;

  // line timing in oscillator ticks, to match the paired encoder
  localparam logic [7:0] ONE_SPLIT_TICKS = 8'h03;
  localparam logic [7:0] MAX_HIGH_TICKS  = 8'h08;
  localparam logic [7:0] MAX_LOW_TICKS   = 8'h08;
  localparam logic [7:0] PILOT_TICKS     = 8'h0C;
  localparam logic [7:0] IDLE_TICKS      = 8'h30;
  localparam logic [7:0] TICK_CNT_MAX    = 8'hFF;

  localparam logic [3:0]  LAST_BIT_IDX   = 4'hB;
  localparam logic [1:0]  MATCHES_NEEDED = 2'h3;
  localparam logic [11:0] ADDR_MASK_8    = 12'h00FF;
  localparam logic [11:0] ADDR_MASK_12   = 12'h0FFF;

  // values after reset
  localparam logic [3:0]  DATA_RESET  = 4'h0;
  localparam logic [1:0]  MATCH_RESET = 2'h0;
  localparam logic [11:0] WORD_RESET  = 12'h0000;

  typedef enum logic [3:0] {
    ST_SLEEP = 4'b0001,
    ST_HUNT  = 4'b0010,
    ST_GAP   = 4'b0100,
    ST_HIGH  = 4'b1000
  } rx_state_t;

  // bit 0 is received first and lands in lower[0]
  typedef struct packed {
    logic [3:0] upper;
    logic [7:0] lower;
  } code_word_t;

  typedef struct packed {
    logic done;
    logic error;
    logic ceased;
  } rx_event_t;

endpackage : remote_code_pkg

//--- verification/code_sender.sv
// code_sender: behavioural paired encoder that drives the serial code line.
// assumes the decoder's tick divider and line timing from the package.
`timescale 1ns/10ps
module code_sender (
  // clock
  input  wire logic clk_sys,
  // serial line
  output logic      serial_line
);
  localparam int TICK = remote_code_pkg::OSC_DIV;

  // idle line is low, which keeps the decoder in standby
  initial serial_line = 1'b0;

  task automatic hold(input logic lvl, input int ticks);
    serial_line = lvl;
    repeat (ticks * TICK) @(negedge clk_sys);
  endtask : hold

  // wake pulse, low pilot, then twelve pulses lsb first; long_bit
  // stretches one pulse past the limit to make a broken word
  task automatic send_word(input logic [11:0] word, input logic long_bit);
    hold(1'b1, 1);
    hold(1'b0, 13);
    for (int i = 0; i < 12; i++) begin
      hold(1'b1, (long_bit && i == 5) ? 9 : (word[i] ? 4 : 2));
      hold(1'b0, 2);
    end
    serial_line = 1'b0;
  endtask : send_word
endmodule : code_sender

//--- verification/remote_code_decoder_tb.sv
// remote_code_decoder_tb: self-checking bench for both decoder variants.
// assumes the sender model; the run is long because line timing is
// fixed in oscillator ticks of many system clocks each.
`timescale 1ns/10ps
module remote_code_decoder_tb;
  localparam int TICK = remote_code_pkg::OSC_DIV;

  logic        clk_sys;
  logic        rst;
  logic        serial_in;
  logic [11:0] straps;
  logic [3:0]  data8;
  logic [3:0]  data12;
  logic        flag8;
  logic        flag12;
  logic        osc8;
  logic        osc_was;
  int          errors;
  int          n_tests;
  int          osc_edges;
  int          osc_n;

  // counts output changes; a running oscillator shows up as growth
  always @(osc8) osc_edges++;

  remote_code_decoder #(.ADDR_BITS(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .serial_in(serial_in),
    .local_address_straps(straps), .latched_data_outputs(data8),
    .valid_transmission_flag(flag8), .rc_osc_output(osc8));
  remote_code_decoder #(.ADDR_BITS(12)) dut12 (
    .clk_sys(clk_sys), .rst(rst), .serial_in(serial_in),
    .local_address_straps(straps), .latched_data_outputs(data12),
    .valid_transmission_flag(flag12), .rc_osc_output());
  code_sender sender (.clk_sys(clk_sys), .serial_line(serial_in));

  task automatic chk_bit(input logic got, input logic exp, input string s);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %b want %b", $time, s, got, exp);
    end
  endtask : chk_bit

  task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp,
                         input string s);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h want %h", $time, s, got, exp);
    end
  endtask : chk_nib

  // one word on the line, then both variants judged
  task automatic word(input logic [11:0] w, input logic bad, input logic f8,
                      input logic f12, input logic [3:0] d8);
    sender.send_word(w, bad);
    chk_bit(flag8, f8, "flag8");
    chk_bit(flag12, f12, "flag12");
    chk_nib(data8, d8, "data8");
    chk_nib(data12, 4'h0, "data12");
  endtask : word

  // oscillator output must stand still while asleep
  task automatic standby_still;
    osc_was = osc8;
    repeat (2000) @(negedge clk_sys);
    chk_bit(osc8, osc_was, "osc");
  endtask : standby_still

  task automatic t_reset;
    chk_bit(flag8, 1'b0, "flag8");
    chk_bit(flag12, 1'b0, "flag12");
    chk_nib(data8, 4'h0, "data8");
    standby_still();
    $display("reset test done");
  endtask : t_reset

  task automatic t_accept;
    osc_n = osc_edges;
    word(12'h6A5, 1'b0, 1'b0, 1'b0, 4'h0);
    chk_bit(osc_edges != osc_n, 1'b1, "osc run");
    word(12'h6A5, 1'b0, 1'b0, 1'b0, 4'h0);
    word(12'h6A5, 1'b0, 1'b1, 1'b1, 4'h6);
    word(12'h9A5, 1'b0, 1'b1, 1'b0, 4'h9);
    $display("accept test done");
  endtask : t_accept

  task automatic t_silence;
    repeat (40 * TICK) @(negedge clk_sys);
    chk_bit(flag8, 1'b1, "flag8");
    repeat (12 * TICK) @(negedge clk_sys);
    chk_bit(flag8, 1'b0, "flag8");
    chk_nib(data8, 4'h9, "data8");
    standby_still();
    $display("silence test done");
  endtask : t_silence

  task automatic t_break;
    word(12'h6A5, 1'b0, 1'b0, 1'b0, 4'h9);
    word(12'h6A5, 1'b0, 1'b0, 1'b0, 4'h9);
    word(12'h6A5, 1'b1, 1'b0, 1'b0, 4'h9);
    word(12'h6A5, 1'b0, 1'b0, 1'b0, 4'h9);
    word(12'h6A5, 1'b0, 1'b0, 1'b0, 4'h9);
    word(12'h3A5, 1'b0, 1'b1, 1'b0, 4'h3);
    word(12'h35A, 1'b0, 1'b0, 1'b0, 4'h3);
    $display("break test done");
  endtask : t_break

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (1_000_000) @(posedge clk_sys);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    straps = 12'h06A5;
    errors = 0;
    n_tests = 0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_accept();
    t_silence();
    t_break();
    wrap_up();
  end
endmodule : remote_code_decoder_tb
